// ### hdl/fsmon_top.sv
// fan speed monitor: pulse counter, period measurement, limits and registers
`timescale 1ns/1ps
`include "fsmon_consts.svh"
module fsmon_top #(
    parameter int REF_DIV = `FSMON_REF_DIV
) (
    input  wire logic        clk_sys,      // system clock, 100 MHz
    input  wire logic        rst,          // async reset, active high
    input  wire logic        fan_pulse_in, // fan tachometer input, asynchronous
    input  wire logic [3:0]  reg_addr,     // register byte offset
    input  wire logic        reg_wr,       // write strobe, one cycle
    input  wire logic        reg_rd,       // read strobe, one cycle
    input  wire logic [31:0] reg_wdata,    // write data
    output logic      [31:0] reg_rdata,    // read data, valid cycle after reg_rd
    output logic             fan_irq       // fan monitor interrupt, level
);
    fsmon_pkg::fsmon_ctrl_t  ctrl;
    fsmon_pkg::fsmon_ctrl_t  next_ctrl;
    fsmon_pkg::fsmon_stat_t  stat;
    fsmon_pkg::fsmon_stat_t  next_stat;
    fsmon_pkg::fsmon_limit_t lim;
    fsmon_pkg::fsmon_limit_t next_lim;
    fsmon_pkg::fsmon_edge_t  pin;
    fsmon_pkg::fsmon_state_t state;
    fsmon_pkg::fsmon_state_t next_state;

    logic [15:0] counter;
    logic [15:0] next_counter;
    logic [15:0] count_field;
    logic [15:0] next_count_field;
    logic [3:0]  edges_seen;
    logic [3:0]  next_edges_seen;
    logic        last_mode;
    logic        next_last_mode;
    logic [31:0] next_rdata;
    logic        ref_tick;
    logic        any_edge;
    logic        period_run;
    logic        latch_evt;
    logic        toggle_evt;
    logic        out_of_range;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        wr_high;
    logic        wr_low;
    logic [3:0]  target;

    function automatic logic [3:0] edge_target(input logic [1:0] sel);
        logic [3:0] n;
        n = 4'h2;
        case (sel)
            2'b00:   n = 4'h2;
            2'b01:   n = 4'h3;
            2'b10:   n = 4'h5;
            2'b11:   n = 4'h9;
            default: n = 4'h2;
        endcase
        return n;
    endfunction

    fsmon_sync #(
        .STAGES   (2)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (fan_pulse_in),
        .edge_out (pin)
    );

    assign period_run = ctrl.enable & ctrl.mode_sel & (state == fsmon_pkg::FSMON_MEAS);

    fsmon_refdiv #(
        .DIV      (REF_DIV)
    ) u_refdiv (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .run      (period_run),
        .tick     (ref_tick)
    );

    assign any_edge = pin.rise | pin.fall;
    assign target   = edge_target(ctrl.edges);

    assign wr_ctrl = reg_wr & (reg_addr == `FSMON_OFF_CTRL);
    assign wr_stat = reg_wr & (reg_addr == `FSMON_OFF_STAT);
    assign wr_high = reg_wr & (reg_addr == `FSMON_OFF_HIGH);
    assign wr_low  = reg_wr & (reg_addr == `FSMON_OFF_LOW);

    // control and limit registers
    always_comb
    begin
        next_ctrl = ctrl;
        next_lim  = lim;
        if (wr_ctrl)
        begin
            next_ctrl.enable   = reg_wdata[`FSMON_CTRL_ENABLE];
            next_ctrl.mode_sel = reg_wdata[`FSMON_CTRL_MODE];
            next_ctrl.edges    = reg_wdata[`FSMON_CTRL_EDGES_HI:`FSMON_CTRL_EDGES_LO];
            next_ctrl.rdy_ie   = reg_wdata[`FSMON_CTRL_RDY_IE];
            next_ctrl.tog_ie   = reg_wdata[`FSMON_CTRL_TOG_IE];
        end
        if (wr_high)
        begin
            next_lim.high = reg_wdata[15:0];
        end
        if (wr_low)
        begin
            next_lim.low = reg_wdata[15:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ctrl     <= '0;
            lim.high <= `FSMON_HIGH_RESET;
            lim.low  <= `FSMON_LOW_RESET;
        end
        else
        begin
            ctrl <= next_ctrl;
            lim  <= next_lim;
        end
    end

    // measurement: counter, edge tally and the readable field
    always_comb
    begin
        next_state       = state;
        next_counter     = counter;
        next_count_field = count_field;
        next_edges_seen  = edges_seen;
        next_last_mode   = ctrl.mode_sel;
        latch_evt        = 1'b0;
        if (!ctrl.enable || (last_mode != ctrl.mode_sel))
        begin
            // a mode switch or disable drops any half-done interval
            next_state      = fsmon_pkg::FSMON_IDLE;
            next_counter    = '0;
            next_edges_seen = '0;
        end
        else if (!ctrl.mode_sel)
        begin
            next_state = fsmon_pkg::FSMON_IDLE;
            if (pin.rise)
            begin
                next_counter     = counter + 16'h0001;
                next_count_field = counter + 16'h0001;
            end
        end
        else
        begin
            case (state)
                fsmon_pkg::FSMON_IDLE:
                begin
                    if (any_edge)
                    begin
                        next_state      = fsmon_pkg::FSMON_MEAS;
                        next_counter    = '0;
                        next_edges_seen = 4'h1;
                    end
                end
                fsmon_pkg::FSMON_MEAS:
                begin
                    if (any_edge && ((edges_seen + 4'h1) == target))
                    begin
                        // closing edge also opens the next interval; a tick in
                        // this cycle belongs to the closing interval, not lost
                        next_count_field = counter + {15'h0000, ref_tick};
                        latch_evt        = 1'b1;
                        next_counter     = '0;
                        next_edges_seen  = 4'h1;
                    end
                    else if (ref_tick && (counter == `FSMON_COUNT_MAX - 16'h0001))
                    begin
                        // stalled fan: report ffff and wait for a fresh edge
                        next_count_field = `FSMON_COUNT_MAX;
                        latch_evt        = 1'b1;
                        next_counter     = '0;
                        next_edges_seen  = '0;
                        next_state       = fsmon_pkg::FSMON_IDLE;
                    end
                    else
                    begin
                        if (ref_tick)
                        begin
                            next_counter = counter + 16'h0001;
                        end
                        if (any_edge)
                        begin
                            next_edges_seen = edges_seen + 4'h1;
                        end
                    end
                end
                default:
                begin
                    next_state = fsmon_pkg::FSMON_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state       <= fsmon_pkg::FSMON_IDLE;
            counter     <= '0;
            count_field <= '0;
            edges_seen  <= '0;
            last_mode   <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            counter     <= next_counter;
            count_field <= next_count_field;
            edges_seen  <= next_edges_seen;
            last_mode   <= next_last_mode;
        end
    end

    // 16-bit count at 100 kHz spans 100 to 30000 rpm with 2..9 edges
    assign out_of_range = (count_field > lim.high) || (count_field < lim.low);
    assign toggle_evt   = ctrl.enable & any_edge;

    // sticky status, write one to clear; a new event beats the clear
    always_comb
    begin
        next_stat = stat;
        if (wr_stat)
        begin
            if (reg_wdata[`FSMON_STAT_LIMIT])
            begin
                next_stat.limit = 1'b0;
            end
            if (reg_wdata[`FSMON_STAT_TOGGLE])
            begin
                next_stat.toggle = 1'b0;
            end
            if (reg_wdata[`FSMON_STAT_READY])
            begin
                next_stat.ready = 1'b0;
            end
        end
        if (out_of_range)
        begin
            next_stat.limit = 1'b1;
        end
        if (toggle_evt)
        begin
            next_stat.toggle = 1'b1;
        end
        if (latch_evt)
        begin
            next_stat.ready = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            stat <= '0;
        end
        else
        begin
            stat <= next_stat;
        end
    end

    // limit flag has no enable of its own, so mode 0 needs limits opened wide
    always_comb
    begin
        fan_irq = stat.limit
                | (stat.ready & ctrl.rdy_ie)
                | (stat.toggle & ctrl.tog_ie);
    end

    // read port; unmapped offsets read as zero
    always_comb
    begin
        next_rdata = reg_rdata;
        if (reg_rd)
        begin
            next_rdata = 32'h0000_0000;
            case (reg_addr)
                `FSMON_OFF_CTRL:
                begin
                    next_rdata[`FSMON_CTRL_COUNT_HI:`FSMON_CTRL_COUNT_LO] = count_field;
                    next_rdata[`FSMON_CTRL_TOG_IE] = ctrl.tog_ie;
                    next_rdata[`FSMON_CTRL_RDY_IE] = ctrl.rdy_ie;
                    next_rdata[`FSMON_CTRL_EDGES_HI:`FSMON_CTRL_EDGES_LO] = ctrl.edges;
                    next_rdata[`FSMON_CTRL_MODE]   = ctrl.mode_sel;
                    next_rdata[`FSMON_CTRL_ENABLE] = ctrl.enable;
                end
                `FSMON_OFF_STAT:
                begin
                    next_rdata[`FSMON_STAT_LIMIT]  = stat.limit;
                    next_rdata[`FSMON_STAT_PIN]    = pin.level;
                    next_rdata[`FSMON_STAT_TOGGLE] = stat.toggle;
                    next_rdata[`FSMON_STAT_READY]  = stat.ready;
                end
                `FSMON_OFF_HIGH:
                begin
                    next_rdata[15:0] = lim.high;
                end
                `FSMON_OFF_LOW:
                begin
                    next_rdata[15:0] = lim.low;
                end
                default:
                begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 32'h0000_0000;
        end
        else
        begin
            reg_rdata <= next_rdata;
        end
    end
endmodule

// ### hdl/fsmon_consts.svh
// register offsets, field positions, reset values and timing counts of the fan speed monitor
// Operation
// - mode 0 counts each rising edge of the synchronised fan pulse input.
// - mode 0 counter wraps from ffff to 0000 and keeps counting.
// - mode 1 counts slow reference clock ticks across the programmed edge count.
// - mode 1 latches the count at the last edge and sets count ready.
// - count ready with its enable set raises the interrupt.
// - count field outside high or low limit sets the limit violation flag.
// - a set limit violation flag raises the interrupt.
// - interrupt output is the OR of the limit flag and the enabled ready and toggle events.
// - reset returns every register and internal state to default.
// - one control bit selects free-running or period mode.
// - readings usable for fans from 100 to 30000 rpm.
// - edge select 00,01,10,11 means 2,3,5,9 edges.
// - mode 1 latches on reaching ffff too, then clears the counter.
// - mode 0 reads never reset the counter; the field tracks each increment.
`ifndef FSMON_CONSTS_SVH
`define FSMON_CONSTS_SVH

`define FSMON_OFF_CTRL        4'h0
`define FSMON_OFF_STAT        4'h4
`define FSMON_OFF_HIGH        4'h8
`define FSMON_OFF_LOW         4'hc

`define FSMON_CTRL_ENABLE     0
`define FSMON_CTRL_MODE       1
`define FSMON_CTRL_EDGES_LO   11
`define FSMON_CTRL_EDGES_HI   12
`define FSMON_CTRL_RDY_IE     14
`define FSMON_CTRL_TOG_IE     15
`define FSMON_CTRL_COUNT_LO   16
`define FSMON_CTRL_COUNT_HI   31

`define FSMON_STAT_LIMIT      0
`define FSMON_STAT_PIN        1
`define FSMON_STAT_TOGGLE     2
`define FSMON_STAT_READY      3

`define FSMON_HIGH_RESET      16'hffff
`define FSMON_LOW_RESET       16'h0000
`define FSMON_COUNT_MAX       16'hffff

`define FSMON_SYS_HZ          100000000
`define FSMON_REF_HZ          100000
`define FSMON_REF_DIV         (`FSMON_SYS_HZ / `FSMON_REF_HZ)

`endif

// ### hdl/fsmon_pkg.sv
// types shared by the fan speed monitor files
package fsmon_pkg;

    typedef struct packed {
        logic       tog_ie;
        logic       rdy_ie;
        logic [1:0] edges;
        logic       mode_sel;
        logic       enable;
    } fsmon_ctrl_t;

    typedef struct packed {
        logic ready;
        logic toggle;
        logic limit;
    } fsmon_stat_t;

    typedef struct packed {
        logic [15:0] high;
        logic [15:0] low;
    } fsmon_limit_t;

    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } fsmon_edge_t;

    typedef enum logic {
        FSMON_IDLE,
        FSMON_MEAS
    } fsmon_state_t;

endpackage

// ### hdl/fsmon_sync.sv
// two-flop synchroniser and edge detector for the fan pulse input
`timescale 1ns/1ps
module fsmon_sync #(
    parameter int STAGES = 2
) (
    input  wire logic                 clk_sys,  // system clock
    input  wire logic                 rst,      // async reset, active high
    input  wire logic                 async_in, // raw pin
    output fsmon_pkg::fsmon_edge_t    edge_out  // level and one-cycle edge pulses
);
    logic [STAGES-1:0] chain;
    logic [STAGES-1:0] next_chain;
    logic              last;
    logic              next_last;

    // only the final stage is looked at; first stage may be metastable
    always_comb
    begin
        next_chain = {chain[STAGES-2:0], async_in};
        next_last  = chain[STAGES-1];
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            chain <= '0;
            last  <= 1'b0;
        end
        else
        begin
            chain <= next_chain;
            last  <= next_last;
        end
    end

    // one driver for the whole struct: level, rise, fall
    assign edge_out = {chain[STAGES-1], chain[STAGES-1] & ~last, ~chain[STAGES-1] & last};
endmodule

// ### hdl/fsmon_refdiv.sv
// divider giving the slow reference tick as a one-cycle enable
`timescale 1ns/1ps
module fsmon_refdiv #(
    parameter int DIV = 1000
) (
    input  wire logic clk_sys, // system clock
    input  wire logic rst,     // async reset, active high
    input  wire logic run,     // divider runs while high
    output logic      tick     // one-cycle pulse at the reference rate
);
    localparam int CW = $clog2(DIV);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_tick;

    // restart on run so the first tick of an interval is a full period
    always_comb
    begin
        next_cnt  = cnt;
        next_tick = 1'b0;
        if (!run)
        begin
            next_cnt = '0;
        end
        else if (cnt == CW'(DIV - 1))
        begin
            next_cnt  = '0;
            next_tick = 1'b1;
        end
        else
        begin
            next_cnt = cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cnt  <= '0;
            tick <= 1'b0;
        end
        else
        begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule

// ### tb/fsmon_chk_sva.sv
// port assertions for the fan speed monitor
`timescale 1ns/1ps
module fsmon_chk #(
    parameter int REF_DIV = 1000
) (
    input wire logic        clk_sys,      // clock
    input wire logic        rst,          // reset
    input wire logic        fan_pulse_in, // fan pin
    input wire logic [3:0]  reg_addr,     // offset
    input wire logic        reg_wr,       // write
    input wire logic        reg_rd,       // read
    input wire logic [31:0] reg_wdata,    // write data
    input wire logic [31:0] reg_rdata,    // read data
    input wire logic        fan_irq       // interrupt
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_rd(logic [3:0] a);
        reg_rd && !reg_wr && reg_addr == a;
    endsequence
    sequence s_wr(logic [3:0] a);
        reg_wr && !reg_rd && reg_addr == a;
    endsequence
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property ($fell(rst) |-> !fan_irq && reg_rdata == 32'h0)
        else $error("outputs not quiet after reset");
    a_limit_upper: assert property (reg_rd && reg_addr[3] |=> reg_rdata[31:16] == 16'h0)
        else $error("limit upper bits set");
    a_pin_level: assert property ($stable(fan_pulse_in)[*4] ##0 s_rd(4'h4)
        |=> reg_rdata[1] == $past(fan_pulse_in))
        else $error("pin level wrong");
    a_irq_fall_write: assert property ($fell(fan_irq) |-> $past(reg_wr))
        else $error("interrupt fell without a write");
    a_ctrl_readback: assert property (s_wr(4'h0) ##1 s_rd(4'h0)
        |=> reg_rdata[15:0] == ($past(reg_wdata[15:0], 2) & 16'hd803))
        else $error("control readback wrong");
    a_limit_readback: assert property (s_wr(4'h8) ##1 s_rd(4'h8)
        |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 2))
        else $error("high limit readback wrong");
endmodule
bind fsmon_top fsmon_chk #(.REF_DIV(REF_DIV)) fsmon_chk_i (
    .clk_sys(clk_sys), .rst(rst), .fan_pulse_in(fan_pulse_in), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fan_irq(fan_irq));

// ### tb/fsmon_fan_model.sv
// behavioural fan: square wave on the tach pin while run is high
`timescale 1ns/1ps
module fsmon_fan_model (
    input  wire logic        clk_sys,  // times the wave
    input  wire logic        run,      // fan spinning
    input  wire logic [15:0] half_cyc, // half period in clocks
    output logic             pulse     // tach output
);
    logic [15:0] cnt;
    initial
    begin
        cnt = 16'h0;
        pulse = 1'b0;
    end
    // a stopped rotor holds its level, so pulses are counted exactly
    always @(negedge clk_sys)
    begin
        if (!run)
            cnt <= 16'h0;
        else if (cnt == half_cyc - 16'h1)
        begin
            cnt <= 16'h0;
            pulse <= ~pulse;
        end
        else
            cnt <= cnt + 16'h1;
    end
endmodule

// ### tb/testbench.sv
// self-checking bench for the fan speed monitor
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin num_errors++; \
    $display("mismatch %s exp %h got %h", nm, ex, got); end end
module testbench;
    localparam int DIV = 5;
    localparam logic [3:0]  RA [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
    localparam logic [31:0] RV [5] = '{32'h0, 32'h0, 32'h0000ffff, 32'h0, 32'h0};
    localparam logic [31:0] LH [4] = '{32'hffff, 32'h10, 32'hffff, 32'h60};
    localparam logic [31:0] LL [4] = '{32'h0, 32'h0, 32'h60, 32'h10};
    localparam logic        LX [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic        clk_sys;
    logic        rst;
    logic        fan_pulse_in;
    logic [3:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic        fan_irq;
    logic        fan_run;
    logic [15:0] fan_half;
    logic [31:0] q;
    int          num_errors;
    int          total_checks;
    fsmon_top #(.REF_DIV(DIV)) fsmon_top_i (
        .clk_sys(clk_sys), .rst(rst), .fan_pulse_in(fan_pulse_in), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .fan_irq(fan_irq));
    fsmon_fan_model fsmon_fan_model_i (
        .clk_sys(clk_sys), .run(fan_run), .half_cyc(fan_half), .pulse(fan_pulse_in));
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // all bus tasks start and end at a falling edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        d = reg_rdata;
        @(negedge clk_sys);
    endtask
    // write then read back on the very next cycle
    task automatic wrrd(input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        r = reg_rdata;
        @(negedge clk_sys);
    endtask
    // rises whole periods, ending low; then lets the synchroniser settle
    task automatic spin(input int rises, input logic [15:0] half);
        fan_half = half;
        fan_run <= 1'b1;
        repeat (rises * 2 * half) @(negedge clk_sys);
        fan_run <= 1'b0;
        repeat (6) @(negedge clk_sys);
    endtask
    task automatic t_defaults();
        for (int i = 0; i < 5; i++)
        begin
            if (i == 4)
                wr(RA[i], 32'hffffffff);
            rd(RA[i], q);
            `CHK("reset value", RV[i], q)
        end
        `CHK("irq idle", 1'b0, fan_irq)
        $display("test defaults done");
    endtask
    task automatic t_mode0();
        logic [15:0] c0;
        wrrd(4'h0, 32'h00000001, q);
        `CHK("ctrl", 16'h0001, q[15:0])
        c0 = q[31:16];
        spin(7, 16'd3);
        rd(4'h0, q);
        `CHK("rises", c0 + 16'd7, q[31:16])
        rd(4'h0, q);
        `CHK("count kept", c0 + 16'd7, q[31:16])
        wr(4'h0, 32'h0);
        spin(3, 16'd3);
        rd(4'h0, q);
        `CHK("stopped", c0 + 16'd7, q[31:16])
        $display("test mode0 done");
    endtask
    task automatic t_mode1();
        int n;
        int ex;
        for (int e = 0; e < 4; e++)
        begin
            n = (e == 0) ? 2 : (e == 1) ? 3 : (e == 2) ? 5 : 9;
            ex = (n - 1) * 22 / DIV;
            wr(4'h4, 32'h0000000f);
            wr(4'h0, {16'h0, 3'b010, e[1:0], 9'h0, 2'b11});
            spin((n + 1) / 2, 16'd22);
            `CHK("irq ready", 1'b1, fan_irq)
            rd(4'h0, q);
            `CHK("period", 1'b1, (q[31:16] - ex[15:0]) <= 16'd1)
            rd(4'h4, q);
            `CHK("ready", 1'b1, q[3])
            // dropping enable closes the open interval so each pass starts fresh
            wr(4'h0, {16'h0, 3'b000, e[1:0], 9'h0, 2'b10});
            `CHK("irq masked", 1'b0, fan_irq)
        end
        $display("test mode1 done");
    endtask
    // count field now holds about 35 ticks
    task automatic t_limits();
        wr(4'h0, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            wrrd(4'h8, LH[i], q);
            wr(4'hc, LL[i]);
            wr(4'h4, 32'h1);
            rd(4'h4, q);
            `CHK("limit flag", LX[i], q[0])
            `CHK("limit irq", LX[i], fan_irq)
        end
        $display("test limits done");
    endtask
    task automatic t_reset();
        wr(4'h8, 32'h1234);
        wr(4'h0, 32'h0000c003);
        rst = 1'b1;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        t_defaults();
        $display("test reset done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        num_errors = 0;
        total_checks = 0;
        rst = 1'b1;
        reg_addr = 4'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 32'h0;
        fan_run = 1'b0;
        fan_half = 16'h1;
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        t_defaults();
        t_mode0();
        t_mode1();
        t_limits();
        t_reset();
        results();
    end
    // whole run needs under a thousand cycles
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        num_errors++;
        $display("mismatch watchdog exp done got hang");
        results();
    end
endmodule
